// ### logic/codec_adc_input_timer_coef_regs.v
// Notes on behaviour
// - Positive routing: three 2-bit off/10k/20k/40k fields
// - Negative routing: common-mode node and first negative
// - Tie unused inputs to common mode when set
// - Status bit 0 shows all gains applied
// - Timer and coefficient defaults valid after 100 us
// - Register 0 selects page, resets to zero
// - Timer clock source bit, resets to external
// - Divider 1..127, zero means 128, reset one
// - Reference clock only times delay, not conversions
// - Coefficient pair is 16-bit two's complement
// - Biquad lead numerator resets to 7FFF, pairs 14/15
`timescale 1ns/1ps
`include "codec_regs.vh"

module codec_adc_input_timer_coef_regs #(
	parameter NUM_COEFS    = 22,  // Pairs from register 2 upward
	parameter VALID_CYCLES = (`DEFAULTS_VALID_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
	core_clk,
	rst_b,
	reg_wr,
	reg_rd,
	reg_addr,
	reg_wdata,
	reg_rdata,
	gain_applied_in,
	bypass_first_pos,
	bypass_second_pos,
	ref_clk_in,
	osc_clk_in,
	page_sel,
	route_first_pos,
	route_second_pos,
	route_first_neg_p,
	route_cm_node,
	route_first_neg,
	tie_first_pos,
	tie_second_pos,
	tie_first_neg,
	timer_src_ext,
	delay_tick,
	defaults_valid,
	coefs
);
	input  wire                  core_clk;          // Device clock, 50 MHz
	input  wire                  rst_b;             // Synchronous reset, low
	input  wire                  reg_wr;            // Control-bus byte write
	input  wire                  reg_rd;            // Control-bus byte read
	input  wire [7:0]            reg_addr;          // Register within page
	input  wire [7:0]            reg_wdata;         // Write byte
	output reg  [7:0]            reg_rdata;         // Read byte, next cycle
	input  wire                  gain_applied_in;   // Analog: gains settled
	input  wire                  bypass_first_pos;  // Analog bypass uses input
	input  wire                  bypass_second_pos; // Analog bypass uses input
	input  wire                  ref_clk_in;        // External reference clock
	input  wire                  osc_clk_in;        // Internal oscillator
	output wire [7:0]            page_sel;          // Selected page
	output wire [1:0]            route_first_pos;   // Feed resistance code
	output wire [1:0]            route_second_pos;  // Feed resistance code
	output wire [1:0]            route_first_neg_p; // Feed resistance code
	output wire [1:0]            route_cm_node;     // Feed resistance code
	output wire [1:0]            route_first_neg;   // Feed resistance code
	output reg                   tie_first_pos;     // Tie to common mode
	output reg                   tie_second_pos;    // Tie to common mode
	output reg                   tie_first_neg;     // Tie to common mode
	output wire                  timer_src_ext;     // 1: reference clock
	output reg                   delay_tick;        // 1 MHz delay-timer tick
	output wire                  defaults_valid;    // Timer/coef pages settled
	output wire [NUM_COEFS*16-1:0] coefs;           // Applied coefficients

	// ----------------------------------------
	// Reset values of the coefficient map
	// ----------------------------------------
	function [15:0] coef_default;
		input integer idx;
		begin
			if (idx == 0 || idx == 1) begin
				coef_default = `COEF_AVG_NUM;
			end else if (idx == 2) begin
				coef_default = `COEF_AVG_DEN;
			end else if (idx == 3) begin
				coef_default = `COEF_UNITY;
			end else if (idx >= 6 && ((idx - 6) % 5) == 0) begin
				coef_default = `COEF_UNITY;
			end else begin
				coef_default = `COEF_ZERO;
			end
		end
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [7:0]  page_reg;          // Page selector
	reg [7:0]  pos_route_reg;     // Positive-terminal routing
	reg [7:0]  neg_route_reg;     // Negative-terminal routing
	reg [7:0]  cm_set_reg;        // Common-mode tie-off bits
	reg [7:0]  timer_clk_reg;     // Timer source and divider
	reg [12:0] valid_cnt_reg;     // Time since reset
	reg        valid_reg;         // Defaults settled
	reg [2:0]  gain_sync_reg;     // Synchroniser, then history
	reg [2:0]  ref_sync_reg;      // Synchroniser plus edge stage
	reg [2:0]  osc_sync_reg;      // Synchroniser plus edge stage
	reg [7:0]  div_cnt_reg;       // Source edges since last tick
	reg [7:0]  rdata_next;        // Read mux

	wire wr_page1 = reg_wr && (page_reg == `PAGE_ROUTING);
	wire wr_page3 = reg_wr && (page_reg == `PAGE_TIMER);
	wire wr_page4 = reg_wr && (page_reg == `PAGE_COEF);

	// ----------------------------------------
	// Page selector and page-one/page-three registers
	// ----------------------------------------
	// Reserved bits are masked off so they always read zero,
	// whatever the host sends there
	always @(posedge core_clk) begin
		if (!rst_b) begin
			page_reg      <= `BYTE_ZERO;
			pos_route_reg <= `POS_ROUTING_RST;
			neg_route_reg <= `NEG_ROUTING_RST;
			cm_set_reg    <= `CM_SETTINGS_RST;
			timer_clk_reg <= `TIMER_CLK_RST;
		end else if (reg_wr) begin
			// Selector answers at offset 0 on every page
			if (reg_addr == `PAGE_SEL_OFS) begin
				page_reg <= reg_wdata;
			end
			if (wr_page1 && reg_addr == `POS_ROUTING_OFS) begin
				pos_route_reg <= reg_wdata & `POS_WRITE_MASK;
			end
			if (wr_page1 && reg_addr == `NEG_ROUTING_OFS) begin
				neg_route_reg <= reg_wdata & `NEG_WRITE_MASK;
			end
			if (wr_page1 && reg_addr == `CM_SETTINGS_OFS) begin
				// Status bit is read-only; write mask drops it
				cm_set_reg <= reg_wdata & `CM_WRITE_MASK;
			end
			// Other timer-page offsets are ignored outright
			if (wr_page3 && reg_addr == `TIMER_CLK_OFS) begin
				timer_clk_reg <= reg_wdata;
			end
		end
	end

	// ----------------------------------------
	// Routing field outputs
	// ----------------------------------------
	assign page_sel          = page_reg;
	assign route_first_pos   = pos_route_reg[`FIRST_POS_HI:`FIRST_POS_LO];
	assign route_second_pos  = pos_route_reg[`SECOND_POS_HI:`SECOND_POS_LO];
	assign route_first_neg_p = pos_route_reg[`FIRST_NEG_POS_HI:`FIRST_NEG_POS_LO];
	assign route_cm_node     = neg_route_reg[`CM_NODE_HI:`CM_NODE_LO];
	assign route_first_neg   = neg_route_reg[`FIRST_NEG_HI:`FIRST_NEG_LO];

	// ----------------------------------------
	// Common-mode tie-off, only for idle inputs
	// ----------------------------------------
	// Registered so the analog switch never sees decode glitches;
	// bypass levels are held static by the analog side
	always @(posedge core_clk) begin
		if (!rst_b) begin
			tie_first_pos  <= 1'b0;
			tie_second_pos <= 1'b0;
			tie_first_neg  <= 1'b0;
		end else begin
			// Positive inputs also count as used by bypass
			tie_first_pos  <= cm_set_reg[`TIE_FIRST_POS_BIT] &&
				route_first_pos == `ROUTE_OFF && !bypass_first_pos;
			tie_second_pos <= cm_set_reg[`TIE_SECOND_POS_BIT] &&
				route_second_pos == `ROUTE_OFF && !bypass_second_pos;
			// Negative input is used if either terminal routes it
			tie_first_neg  <= cm_set_reg[`TIE_FIRST_NEG_BIT] &&
				route_first_neg_p == `ROUTE_OFF &&
				route_first_neg == `ROUTE_OFF;
		end
	end

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// Stage 0 feeds only stage 1; logic reads stage 1 and beyond
	always @(posedge core_clk) begin
		if (!rst_b) begin
			gain_sync_reg <= 3'h0;
			ref_sync_reg  <= 3'h0;
			osc_sync_reg  <= 3'h0;
		end else begin
			gain_sync_reg <= {gain_sync_reg[1:0], gain_applied_in};
			ref_sync_reg  <= {ref_sync_reg[1:0], ref_clk_in};
			osc_sync_reg  <= {osc_sync_reg[1:0], osc_clk_in};
		end
	end

	// ----------------------------------------
	// Delay-timer tick divider
	// ----------------------------------------
	// Source clocks are sampled, so each must stay under a quarter
	// of the core clock; the tick only paces the delay timer and
	// never reaches conversion timing
	wire       ref_edge = ref_sync_reg[1] & ~ref_sync_reg[2];
	wire       osc_edge = osc_sync_reg[1] & ~osc_sync_reg[2];
	wire       src_edge = timer_src_ext ? ref_edge : osc_edge;
	wire [6:0] div_code = timer_clk_reg[`TIMER_DIV_HI:`TIMER_DIV_LO];
	wire [7:0] div_lim  = (div_code == `DIV_ZERO_CODE) ?
		`DIV_FULL_COUNT : {1'b0, div_code};

	assign timer_src_ext = timer_clk_reg[`TIMER_SRC_BIT];

	// Count source edges; tick on the edge that completes a period
	always @(posedge core_clk) begin
		if (!rst_b) begin
			div_cnt_reg <= `BYTE_ZERO;
			delay_tick  <= 1'b0;
		end else begin
			delay_tick <= 1'b0;
			if (src_edge) begin
				if (div_cnt_reg + 8'h01 >= div_lim) begin
					div_cnt_reg <= `BYTE_ZERO;
					delay_tick  <= 1'b1;
				end else begin
					div_cnt_reg <= div_cnt_reg + 8'h01;
				end
			end
		end
	end

	// ----------------------------------------
	// Settling time after reset
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (!rst_b) begin
			valid_cnt_reg <= 13'h0000;
			valid_reg     <= 1'b0;
		end else if (!valid_reg) begin
			if (valid_cnt_reg == VALID_CYCLES[12:0] - 13'h0001) begin
				valid_reg <= 1'b1;
			end
			valid_cnt_reg <= valid_cnt_reg + 13'h0001;
		end
	end

	assign defaults_valid = valid_reg;

	// ----------------------------------------
	// Coefficient pairs
	// ----------------------------------------
	wire [NUM_COEFS*8-1:0] hi_bytes; // Readback, upper bytes
	wire [NUM_COEFS*8-1:0] lo_bytes; // Readback, lower bytes

	genvar gi;
	generate
		for (gi = 0; gi < NUM_COEFS; gi = gi + 1) begin : g_coef
			// Offsets of this pair on the coefficient page; the sum is
			// integer wide, so it is cut to the address width on purpose
			wire [31:0] hi_sum = `COEF_FIRST_OFS + gi * 2;
			wire [7:0]  hi_ofs = hi_sum[7:0];
			wire [7:0]  lo_ofs = hi_ofs + 8'h01;
			coef_pair #(
				.RESET_VAL (coef_default(gi))
			) u_pair (
				.core_clk (core_clk),
				.rst_b    (rst_b),
				.wr_hi    (wr_page4 && reg_addr == hi_ofs),
				.wr_lo    (wr_page4 && reg_addr == lo_ofs),
				.wr_data  (reg_wdata),
				.hi_byte  (hi_bytes[gi*8 +: 8]),
				.lo_byte  (lo_bytes[gi*8 +: 8]),
				.coef     (coefs[gi*16 +: 16])
			);
		end
	endgenerate

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	// Unused and reserved offsets read zero; timer and coefficient
	// pages read zero, except the selector at offset 0, until their defaults have settled
	integer k;
	always @* begin
		rdata_next = `BYTE_ZERO;
		if (reg_addr == `PAGE_SEL_OFS) begin
			rdata_next = page_reg;
		end else if (page_reg == `PAGE_ROUTING) begin
			case (reg_addr)
				`POS_ROUTING_OFS: rdata_next = pos_route_reg;
				`NEG_ROUTING_OFS: rdata_next = neg_route_reg;
				`CM_SETTINGS_OFS: begin
					rdata_next = cm_set_reg;
					rdata_next[`GAIN_APPLIED_BIT] = gain_sync_reg[1];
				end
				default: rdata_next = `BYTE_ZERO;
			endcase
		end else if (page_reg == `PAGE_TIMER && valid_reg) begin
			if (reg_addr == `TIMER_CLK_OFS) begin
				rdata_next = timer_clk_reg;
			end
		end else if (page_reg == `PAGE_COEF && valid_reg) begin
			for (k = 0; k < NUM_COEFS; k = k + 1) begin
				if (reg_addr == `COEF_FIRST_OFS + k * 2) begin
					rdata_next = hi_bytes[k*8 +: 8];
				end
				if (reg_addr == `COEF_FIRST_OFS + k * 2 + 1) begin
					rdata_next = lo_bytes[k*8 +: 8];
				end
			end
		end
	end

	// Read data registered, valid the cycle after the strobe
	always @(posedge core_clk) begin
		if (!rst_b) begin
			reg_rdata <= `BYTE_ZERO;
		end else if (reg_rd) begin
			reg_rdata <= rdata_next;
		end
	end

endmodule

// ### shared/codec_regs.vh
`ifndef CODEC_ADC_TIMER_COEF_REGS_VH
`define CODEC_ADC_TIMER_COEF_REGS_VH

// ----------------------------------------
// Pages and register offsets
// ----------------------------------------
`define PAGE_SEL_OFS        8'h00
`define PAGE_ROUTING        8'h01
`define PAGE_TIMER          8'h03
`define PAGE_COEF           8'h04
`define POS_ROUTING_OFS     8'h30
`define NEG_ROUTING_OFS     8'h31
`define CM_SETTINGS_OFS     8'h32
`define TIMER_CLK_OFS       8'h10
`define COEF_FIRST_OFS      8'h02

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FIRST_POS_HI        7
`define FIRST_POS_LO        6
`define SECOND_POS_HI       5
`define SECOND_POS_LO       4
`define FIRST_NEG_POS_HI    3
`define FIRST_NEG_POS_LO    2
`define CM_NODE_HI          7
`define CM_NODE_LO          6
`define FIRST_NEG_HI        5
`define FIRST_NEG_LO        4
`define TIE_FIRST_POS_BIT   7
`define TIE_SECOND_POS_BIT  6
`define TIE_FIRST_NEG_BIT   5
`define GAIN_APPLIED_BIT    0
`define TIMER_SRC_BIT       7
`define TIMER_DIV_HI        6
`define TIMER_DIV_LO        0

// ----------------------------------------
// Reset values and encodings
// ----------------------------------------
`define BYTE_ZERO           8'h00
`define ROUTE_OFF           2'h0
`define POS_ROUTING_RST     8'h00
`define NEG_ROUTING_RST     8'h00
`define CM_SETTINGS_RST     8'h00
`define TIMER_CLK_RST       8'h81
`define POS_WRITE_MASK      8'hFC
`define NEG_WRITE_MASK      8'hF0
`define CM_WRITE_MASK       8'hE0
`define DIV_ZERO_CODE       7'h00
`define DIV_FULL_COUNT      8'h80
`define COEF_UNITY          16'h7FFF
`define COEF_AVG_NUM        16'h0117
`define COEF_AVG_DEN        16'h7DD3
`define COEF_ZERO           16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define DEFAULTS_VALID_NS   100000
`define CLK_PERIOD_NS       20

`endif

// ### logic/coef_pair.v
`timescale 1ns/1ps

// ----------------------------------------
// One coefficient: upper byte staged until lower byte lands
// ----------------------------------------
module coef_pair #(
	parameter [15:0] RESET_VAL = 16'h0000
) (
	core_clk,
	rst_b,
	wr_hi,
	wr_lo,
	wr_data,
	hi_byte,
	lo_byte,
	coef
);
	input  wire        core_clk;  // Device clock
	input  wire        rst_b;     // Synchronous reset, low
	input  wire        wr_hi;     // Upper byte write strobe
	input  wire        wr_lo;     // Lower byte write strobe
	input  wire [7:0]  wr_data;   // Write byte
	output wire [7:0]  hi_byte;   // Readback upper byte
	output wire [7:0]  lo_byte;   // Readback lower byte
	output wire [15:0] coef;      // Value seen by the filter

	reg [7:0]  hi_stage_reg;      // Upper byte waiting for its partner
	reg [15:0] coef_reg;          // Applied two's-complement value

	// Stage upper byte; commit pair on lower-byte write
	always @(posedge core_clk) begin
		if (!rst_b) begin
			hi_stage_reg <= RESET_VAL[15:8];
			coef_reg     <= RESET_VAL;
		end else begin
			if (wr_hi) begin
				hi_stage_reg <= wr_data;
			end
			if (wr_lo) begin
				// Whole word swaps at once, never half old, half new
				coef_reg <= {hi_stage_reg, wr_data};
			end
		end
	end

	assign hi_byte = hi_stage_reg;
	assign lo_byte = coef_reg[7:0];
	assign coef    = coef_reg;

endmodule

// ### bench/codec_regs_asserts.sv
`timescale 1ns/1ps

// ----------
// Port checks for the codec register slice
// ----------
module codec_regs_asserts #(
	parameter NUM_COEFS    = 22,
	parameter VALID_CYCLES = 20
) (
	input logic                    core_clk,
	input logic                    rst_b,
	input logic                    reg_wr,
	input logic                    reg_rd,
	input logic [7:0]              reg_addr,
	input logic [7:0]              reg_wdata,
	input logic [7:0]              reg_rdata,
	input logic                    gain_applied_in,
	input logic                    bypass_first_pos,
	input logic [7:0]              page_sel,
	input logic [1:0]              route_first_pos,
	input logic [1:0]              route_first_neg_p,
	input logic [1:0]              route_cm_node,
	input logic [1:0]              route_first_neg,
	input logic                    tie_first_pos,
	input logic                    timer_src_ext,
	input logic                    delay_tick,
	input logic                    defaults_valid,
	input logic [NUM_COEFS*16-1:0] coefs
);
	int cnt; // Cycles since reset release, saturating
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// Saturates a little past the window so the upper check stays armed
	always @(posedge core_clk) begin
		if (!rst_b) cnt <= 0;
		else if (cnt < VALID_CYCLES + 4) cnt <= cnt + 1;
	end
	property p_page; reg_wr && reg_addr == 8'h00 |=> page_sel == $past(reg_wdata); endproperty
	property p_pos; reg_wr && page_sel == 8'h01 && reg_addr == 8'h30 |=>
		{route_first_pos, route_first_neg_p} == {$past(reg_wdata[7:6]), $past(reg_wdata[3:2])};
	endproperty
	property p_neg; reg_wr && page_sel == 8'h01 && reg_addr == 8'h31 |=>
		{route_cm_node, route_first_neg} == $past(reg_wdata[7:4]); endproperty
	// Status only trusted once the async input has sat still
	property p_gain; $stable(gain_applied_in)[*4] ##0 (reg_rd && page_sel == 8'h01 &&
		reg_addr == 8'h32) |=> reg_rdata[0] == $past(gain_applied_in); endproperty
	property p_src; reg_wr && page_sel == 8'h03 && reg_addr == 8'h10 |=>
		timer_src_ext == $past(reg_wdata[7]); endproperty
	property p_valid_lo; cnt < VALID_CYCLES |-> !defaults_valid; endproperty
	property p_valid_hi; cnt >= VALID_CYCLES |-> defaults_valid; endproperty
	property p_gate; reg_rd && !defaults_valid && (page_sel == 8'h03 || page_sel == 8'h04)
		|=> reg_rdata == 8'h00; endproperty
	property p_tick; delay_tick |=> !delay_tick; endproperty
	property p_hold; !$stable(coefs) |-> $past(reg_wr) && $past(page_sel) == 8'h04 &&
		$past(reg_addr[0]);
	endproperty
	property p_pair; reg_wr && page_sel == 8'h04 && reg_addr == 8'h0E ##1 reg_wr &&
		reg_addr == 8'h0F |=> coefs[111:96] == {$past(reg_wdata, 2), $past(reg_wdata)};
	endproperty
	property p_tie; tie_first_pos |-> $past(route_first_pos) == 2'h0 && !$past(bypass_first_pos);
	endproperty
	a_page: assert property (p_page) else $error("page select wrong");
	a_pos: assert property (p_pos) else $error("positive routing wrong");
	a_neg: assert property (p_neg) else $error("negative routing wrong");
	a_gain: assert property (p_gain) else $error("gain status wrong");
	a_src: assert property (p_src) else $error("timer source wrong");
	a_valid_lo: assert property (p_valid_lo) else $error("defaults valid early");
	a_valid_hi: assert property (p_valid_hi) else $error("defaults valid late");
	a_gate: assert property (p_gate) else $error("early read not zero");
	a_tick: assert property (p_tick) else $error("tick too long");
	a_hold: assert property (p_hold) else $error("coef changed without low write");
	a_pair: assert property (p_pair) else $error("coef pair wrong");
	a_tie: assert property (p_tie) else $error("tie on used input");
	c_pair: cover property (reg_wr && page_sel == 8'h04 && reg_addr == 8'h0F);
	c_tick: cover property (delay_tick);
	c_tie: cover property (tie_first_pos);
endmodule

bind codec_adc_input_timer_coef_regs codec_regs_asserts #(
	.NUM_COEFS(NUM_COEFS), .VALID_CYCLES(VALID_CYCLES)
) codec_regs_asserts_inst (
	.core_clk(core_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.gain_applied_in(gain_applied_in), .bypass_first_pos(bypass_first_pos),
	.page_sel(page_sel), .route_first_pos(route_first_pos),
	.route_first_neg_p(route_first_neg_p), .route_cm_node(route_cm_node),
	.route_first_neg(route_first_neg), .tie_first_pos(tie_first_pos),
	.timer_src_ext(timer_src_ext), .delay_tick(delay_tick),
	.defaults_valid(defaults_valid), .coefs(coefs)
);

// ### bench/host_model.sv
`timescale 1ns/1ps

// ----------
// Control-bus host, one byte per strobe
// ----------
module host_model (
	input  logic       core_clk,
	output logic       reg_wr,
	output logic       reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata
);
	logic [7:0] exp_q[$]; // Expected read bytes, oldest first
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// Callers write zeros in reserved bits and only mapped places
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d; // No stale byte left on the bus
	endtask
	// Upper byte, then the lower byte on the very next edge
	// Strobe stays up across both bytes; nothing assigned twice per edge
	task wpair(input logic [7:0] a, input logic [15:0] v);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v[15:8];
		@(posedge core_clk);
		reg_addr <= a + 8'h01;
		reg_wdata <= v[7:0];
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask
endmodule

// ### bench/codec_adc_input_timer_coef_regs_test.sv
`timescale 1ns/1ps

module codec_adc_input_timer_coef_regs_test;
	localparam VC = 20; // Shortened defaults window
	logic rst_b, gain_applied_in, bypass_first_pos, bypass_second_pos;
	logic core_clk = 1'b0, ref_clk_in = 1'b0, osc_clk_in = 1'b0; // Free-running sources
	logic reg_wr, reg_rd, timer_src_ext, delay_tick, defaults_valid;
	logic tie_first_pos, tie_second_pos, tie_first_neg, rd_seen = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, page_sel;
	logic [1:0] route_first_pos, route_second_pos, route_first_neg_p, route_cm_node;
	logic [1:0] route_first_neg;
	logic [351:0] coefs;
	logic [31:0] seed = 32'h0000000E; // xorshift state
	logic [31:0] r;
	int fail_count = 0, compares = 0, cyc = 0, ph = 0, i, k, n;

	codec_adc_input_timer_coef_regs #(.VALID_CYCLES(VC)) codec_adc_input_timer_coef_regs_inst (
		.core_clk(core_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.gain_applied_in(gain_applied_in), .bypass_first_pos(bypass_first_pos),
		.bypass_second_pos(bypass_second_pos), .ref_clk_in(ref_clk_in),
		.osc_clk_in(osc_clk_in), .page_sel(page_sel), .route_first_pos(route_first_pos),
		.route_second_pos(route_second_pos), .route_first_neg_p(route_first_neg_p),
		.route_cm_node(route_cm_node), .route_first_neg(route_first_neg),
		.tie_first_pos(tie_first_pos), .tie_second_pos(tie_second_pos),
		.tie_first_neg(tie_first_neg), .timer_src_ext(timer_src_ext),
		.delay_tick(delay_tick), .defaults_valid(defaults_valid), .coefs(coefs));
	host_model host_model_inst (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));

	// ----------
	// Clocks, helpers, watcher
	// ----------
	always #10 core_clk = ~core_clk;
	// Slow sources: reference 10 cycles, oscillator 14 cycles a period
	always @(posedge core_clk) begin
		ph <= ph + 1;
		cyc <= cyc + 1;
		if (ph % 5 == 0) ref_clk_in <= ~ref_clk_in;
		if (ph % 7 == 0) osc_clk_in <= ~osc_clk_in;
		if (cyc == 20000) begin
			fail_count++;
			results();
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Read byte lands the edge after the strobe
	always @(posedge core_clk) begin
		rd_seen <= reg_rd;
		if (rd_seen === 1'b1) chk("reg_rdata", {8'h00, host_model_inst.exp_q.pop_front()}, {8'h00, reg_rdata});
	end
	// Bounded wait for the next tick, counting edges
	task wait_tick();
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (delay_tick !== 1'b1 && n < 4000);
	endtask
	// First two gaps may straddle the divider change
	task tick_gap(input logic [7:0] code, input int gap);
		host_model_inst.wr(8'h10, code);
		repeat (3) wait_tick();
		chk("tick gap", gap[15:0], n[15:0]);
		chk("timer_src_ext", {15'h0000, code[7]}, {15'h0000, timer_src_ext});
	endtask
	task results();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// ----------
	// Main sequence
	// ----------
	initial begin
		{rst_b, gain_applied_in, bypass_first_pos, bypass_second_pos} = 4'h0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		@(negedge core_clk);
		chk("page_sel", 16'h0000, {8'h00, page_sel});
		host_model_inst.wr(8'h00, 8'h03);
		host_model_inst.rd(8'h10, 8'h00);
		repeat (VC + 4) @(posedge core_clk);
		host_model_inst.rd(8'h10, 8'h81);
		host_model_inst.wr(8'h00, 8'h04);
		host_model_inst.rd(8'h0E, 8'h7F);
		host_model_inst.rd(8'h0F, 8'hFF);
		$display("test reset values done");
		host_model_inst.wr(8'h00, 8'h01);
		for (i = 0; i < 4; i++) begin
			r = rnd();
			host_model_inst.wr(8'h30, r[7:0] & 8'hFC);
			host_model_inst.wr(8'h31, r[15:8] & 8'hF0);
			host_model_inst.rd(8'h30, r[7:0] & 8'hFC);
			host_model_inst.rd(8'h31, r[15:8] & 8'hF0);
			chk("routing", {6'h00, r[7:2], r[15:12]}, {6'h00, route_first_pos, route_second_pos,
				route_first_neg_p, route_cm_node, route_first_neg});
		end
		// All positive-routing fields at their widest code; reserved bits kept zero
		host_model_inst.wr(8'h30, 8'hFC);
		host_model_inst.rd(8'h30, 8'hFC);
		host_model_inst.rd(8'h33, 8'h00);
		$display("test routing done");
		host_model_inst.wr(8'h30, 8'h00);
		host_model_inst.wr(8'h31, 8'h00);
		host_model_inst.wr(8'h32, 8'hE0);
		gain_applied_in <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk("ties", 16'h0007, {13'h0000, tie_first_pos, tie_second_pos, tie_first_neg});
		host_model_inst.rd(8'h32, 8'hE1);
		bypass_first_pos <= 1'b1;
		gain_applied_in <= 1'b0;
		host_model_inst.wr(8'h30, 8'h10);
		repeat (4) @(posedge core_clk);
		chk("ties", 16'h0001, {13'h0000, tie_first_pos, tie_second_pos, tie_first_neg});
		host_model_inst.rd(8'h32, 8'hE0);
		$display("test common mode done");
		host_model_inst.wr(8'h00, 8'h03);
		tick_gap(8'h05, 70);
		tick_gap(8'h83, 30);
		tick_gap(8'h80, 1280);
		$display("test timer done");
		host_model_inst.wr(8'h00, 8'h04);
		// Lower byte is the very next access after the upper byte
		host_model_inst.wr(8'h0E, 8'h80);
		@(negedge core_clk);
		chk("held coef", 16'h7FFF, coefs[111:96]);
		host_model_inst.wr(8'h0F, 8'h01);
		@(negedge core_clk);
		chk("coef", 16'h8001, coefs[111:96]);
		host_model_inst.rd(8'h0E, 8'h80);
		for (i = 0; i < 5; i++) begin
			r = rnd();
			k = (i == 0) ? 6 : r[20:16] % 22;
			if (i == 1) r[15:0] = 16'h8000;
			host_model_inst.wpair(8'(2 + 2 * k), r[15:0]);
			@(negedge core_clk);
			chk("coef", r[15:0], coefs[k * 16 +: 16]);
			host_model_inst.rd(8'(3 + 2 * k), r[7:0]);
		end
		$display("test coefficients done");
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		@(negedge core_clk);
		chk("page_sel", 16'h0000, {8'h00, page_sel});
		chk("coef reset", 16'h7FFF, coefs[111:96]);
		$display("test second reset done");
		results();
	end
endmodule
